// ### i2c_match_pkg.sv
// constants for the address matcher and smbus timeout block
package i2c_match_pkg;
  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned LOW_TIMEOUT_MS    = 35;
  localparam int unsigned LOW_TIMEOUT_CYC   = CLK_HZ / 1000 * LOW_TIMEOUT_MS;
  localparam int          CNT_W             = 24;
  localparam logic [4:0]  TEN_BIT_PREFIX    = 5'h1e;
  localparam logic [6:0]  GENERAL_CALL_ADDR = 7'h00;
  localparam logic [6:0]  ALERT_RESP_ADDR   = 7'h0c;
  localparam logic [3:0]  BIT_COUNT_ACK     = 4'h8;
  localparam logic [3:0]  BIT_COUNT_DONE    = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR1  = 3'b001,
    ST_ADDR2  = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_IGNORE = 3'b100
  } phase_type;
endpackage

// ### i2c_addr_match.sv
// slave address recognition and smbus timeout detection
module i2c_addr_match
(
  input  wire logic                           mclk,
  input  wire logic                           nrst,
  input  wire logic                           scl_in,
  input  wire logic                           sda_in,
  input  wire logic [9:0]                     own_address,
  input  wire logic                           address_extension_enable,
  input  wire logic                           general_call_enable,
  input  wire logic                           alert_response_enable,
  input  wire logic                           second_address_enable,
  input  wire logic [6:0]                     second_address,
  input  wire logic                           range_match_enable,
  input  wire logic [6:0]                     range_address,
  input  wire logic                           master_active,
  input  wire logic                           master_stretching,
  input  wire logic                           slave_stretching,
  input  wire logic [i2c_match_pkg::CNT_W-1:0] high_timeout_cycles,
  input  wire logic [i2c_match_pkg::CNT_W-1:0] data_low_timeout_cycles,
  input  wire logic [i2c_match_pkg::CNT_W-1:0] master_ext_cycles,
  input  wire logic [i2c_match_pkg::CNT_W-1:0] slave_ext_cycles,
  input  wire logic                           flag_clear,
  output logic                                sda_out,
  output logic                                sda_oe,
  output logic                                scl_out,
  output logic                                scl_oe,
  output logic                                addressed_as_slave_flag,
  output logic                                slave_transmit,
  output logic                                transfer_pulse,
  output logic                                bus_idle_high_timeout_flag,
  output logic                                data_low_timeout_flag,
  output logic                                clock_low_timeout_flag,
  output logic                                module_interrupt_flag,
  output logic                                master_extension_flag,
  output logic                                slave_extension_flag,
  output logic                                master_stop_request
);
  import i2c_match_pkg::*;

  logic [2:0]       scl_sync_reg;
  logic [2:0]       sda_sync_reg;
  logic             scl_reg;
  logic             sda_reg;
  phase_type        phase_reg;
  logic [3:0]       bit_cnt_reg;
  logic [7:0]       shift_reg;
  logic             ten_sel_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] high_cnt_reg;
  logic [CNT_W-1:0] sdalow_cnt_reg;
  logic [CNT_W-1:0] master_extension_flag_cnt_reg;
  logic [CNT_W-1:0] slave_extension_flag_cnt_reg;
  logic             ack_pending_reg;
  logic             scl_prev_reg;
  logic             sda_prev_reg;

  // sync stage 0 feeds stage 1 only; agreement of stages 1 and 2 is a change
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_reg <= sda_sync_reg[2];
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise   = scl_reg & ~scl_prev_reg;
  assign scl_fall   = ~scl_reg & scl_prev_reg;
  assign start_seen = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
  assign stop_seen  = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;

  // address comparison on each complete address byte
  logic [7:0] byte_in;
  logic       prim_match;
  logic       extra_match;
  logic       ten_first_match;
  logic       ten_second_match;
  assign byte_in = shift_reg;
  assign prim_match = ~address_extension_enable & (byte_in[7:1] == own_address[6:0]);
  // optional extra addresses; range excludes primary itself
  assign extra_match = ~address_extension_enable & (
      (general_call_enable & (byte_in[7:1] == GENERAL_CALL_ADDR)) |
      (alert_response_enable & (byte_in[7:1] == ALERT_RESP_ADDR)) |
      (second_address_enable & (byte_in[7:1] == second_address)) |
      (range_match_enable & (range_address != 7'h00) &
       (byte_in[7:1] > own_address[6:0]) & (byte_in[7:1] <= range_address)));
  // ten-bit prefix only when extension set; 7-bit compares are gated off then
  assign ten_first_match = address_extension_enable &
      (byte_in[7:3] == TEN_BIT_PREFIX) & (byte_in[2:1] == own_address[9:8]);
  assign ten_second_match = (byte_in == own_address[7:0]);

  logic timeout_reset;
  assign timeout_reset = (low_cnt_reg >= LOW_TIMEOUT_CYC[CNT_W-1:0]);

  // address phase state machine
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_reg       <= ST_IDLE;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 8'h00;
      ten_sel_reg     <= 1'b0;
      ack_pending_reg <= 1'b0;
      slave_transmit  <= 1'b0;
      transfer_pulse  <= 1'b0;
      addressed_as_slave_flag <= 1'b0;
    end
    else
    begin
      transfer_pulse <= 1'b0;
      if (flag_clear)
        addressed_as_slave_flag <= 1'b0;
      // timeout drops selection and releases the lines
      if (timeout_reset | stop_seen)
      begin
        phase_reg       <= ST_IDLE;
        ten_sel_reg     <= 1'b0;
        ack_pending_reg <= 1'b0;
        slave_transmit  <= 1'b0;
      end
      else if (start_seen)
      begin
        phase_reg       <= ST_ADDR1;
        bit_cnt_reg     <= 4'h0;
        ack_pending_reg <= 1'b0;
      end
      else
      begin
        if (scl_rise & (phase_reg != ST_IDLE))
        begin
          shift_reg   <= {shift_reg[6:0], sda_reg};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (scl_fall & (bit_cnt_reg == BIT_COUNT_ACK))
        begin
          case (phase_reg)
            ST_ADDR1:
            begin
              if (ten_first_match & ~byte_in[0])
              begin
                ack_pending_reg <= 1'b1;
                ten_sel_reg     <= 1'b0;
                phase_reg       <= ST_ADDR2;
                // transfer pulse after the first byte
                transfer_pulse  <= 1'b1;
              end
              else if (ten_first_match & byte_in[0] & ten_sel_reg)
              begin
                // read after restart makes us transmitter
                ack_pending_reg <= 1'b1;
                slave_transmit  <= 1'b1;
                phase_reg       <= ST_ACTIVE;
                addressed_as_slave_flag <= 1'b1;
              end
              else if (prim_match | extra_match)
              begin
                // direction from the r/w bit, flag after address
                ack_pending_reg <= 1'b1;
                slave_transmit  <= byte_in[0];
                phase_reg       <= ST_ACTIVE;
                addressed_as_slave_flag <= 1'b1;
              end
              else
              begin
                ten_sel_reg <= 1'b0;
                phase_reg   <= ST_IGNORE;
              end
            end
            ST_ADDR2:
            begin
              if (ten_second_match)
              begin
                ack_pending_reg <= 1'b1;
                ten_sel_reg     <= 1'b1;
                slave_transmit  <= 1'b0;
                phase_reg       <= ST_ACTIVE;
                addressed_as_slave_flag <= 1'b1;
              end
              else
                phase_reg <= ST_IGNORE;
            end
            default: phase_reg <= phase_reg;
          endcase
        end
        if (scl_fall & (bit_cnt_reg == BIT_COUNT_DONE))
        begin
          ack_pending_reg <= 1'b0;
          bit_cnt_reg     <= 4'h0;
        end
      end
    end
  end

  // open-drain drive; clock is never stretched here
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= ack_pending_reg & ~timeout_reset;
    end
  end

  // clock low counter restarts on each scl change
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      low_cnt_reg <= '0;
    else if (scl_reg)
      low_cnt_reg <= '0;
    else if (!timeout_reset)
      low_cnt_reg <= low_cnt_reg + 1'b1;
  end

  // high and data-low counters restart on line changes
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      high_cnt_reg   <= '0;
      sdalow_cnt_reg <= '0;
      bus_idle_high_timeout_flag <= 1'b0;
    end
    else
    begin
      if (!(scl_reg & sda_reg))
        high_cnt_reg <= '0;
      else if (high_cnt_reg != high_timeout_cycles)
        high_cnt_reg <= high_cnt_reg + 1'b1;
      if (!(scl_reg & ~sda_reg))
        sdalow_cnt_reg <= '0;
      else if (sdalow_cnt_reg != data_low_timeout_cycles)
        sdalow_cnt_reg <= sdalow_cnt_reg + 1'b1;
      // idle indication follows the bus, no clear needed
      bus_idle_high_timeout_flag <= (high_timeout_cycles != '0) &
                                    (high_cnt_reg == high_timeout_cycles);
    end
  end

  logic byte_boundary;
  assign byte_boundary = start_seen | stop_seen | (scl_fall & (bit_cnt_reg == BIT_COUNT_DONE));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      master_extension_flag_cnt_reg <= '0;
      slave_extension_flag_cnt_reg <= '0;
    end
    else
    begin
      if (byte_boundary)
        master_extension_flag_cnt_reg <= '0;
      else if (master_active & master_stretching & ~scl_reg &
               (master_extension_flag_cnt_reg != master_ext_cycles))
        master_extension_flag_cnt_reg <= master_extension_flag_cnt_reg + 1'b1;
      if (start_seen | stop_seen)
        slave_extension_flag_cnt_reg <= '0;
      else if (slave_stretching & ~scl_reg & (slave_extension_flag_cnt_reg != slave_ext_cycles))
        slave_extension_flag_cnt_reg <= slave_extension_flag_cnt_reg + 1'b1;
    end
  end

  logic master_extension_flag_hit;
  logic slave_extension_flag_hit;
  logic sdalow_hit;
  assign master_extension_flag_hit   = (master_ext_cycles != '0) & (master_extension_flag_cnt_reg == master_ext_cycles);
  assign slave_extension_flag_hit   = (slave_ext_cycles != '0) & (slave_extension_flag_cnt_reg == slave_ext_cycles);
  assign sdalow_hit = (data_low_timeout_cycles != '0) &
                      (sdalow_cnt_reg == data_low_timeout_cycles);

  // sticky flags; a new event wins over flag_clear in the same cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_low_timeout_flag <= 1'b0;
      data_low_timeout_flag  <= 1'b0;
      master_extension_flag  <= 1'b0;
      slave_extension_flag   <= 1'b0;
      module_interrupt_flag  <= 1'b0;
      master_stop_request    <= 1'b0;
    end
    else
    begin
      // low-timeout flag from all three causes
      clock_low_timeout_flag <= timeout_reset | master_extension_flag_hit | slave_extension_flag_hit |
                                (clock_low_timeout_flag & ~flag_clear);
      // data low flag also sets the interrupt flag
      data_low_timeout_flag  <= sdalow_hit | (data_low_timeout_flag & ~flag_clear);
      master_extension_flag  <= master_extension_flag_hit | (master_extension_flag & ~flag_clear);
      slave_extension_flag   <= slave_extension_flag_hit | (slave_extension_flag & ~flag_clear);
      module_interrupt_flag  <= sdalow_hit | timeout_reset | master_extension_flag_hit | slave_extension_flag_hit |
                                transfer_pulse | (module_interrupt_flag & ~flag_clear);
      // master asked to stop at once on a clock low timeout or master extension
      if (!master_active | stop_seen)
        master_stop_request <= 1'b0;
      else if (timeout_reset | master_extension_flag_hit)
        master_stop_request <= 1'b1;
    end
  end
endmodule

// ### i2c_master_model.sv
// behavioural bus master pulling scl and sda as open drain
module i2c_master_model (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // sda is pulled or released at once; the bus is not checked for idle
  task automatic hold_sda(input logic v);
    sda_pull = v;
  endtask

  task automatic qtr();
    repeat (2) @(negedge mclk);
  endtask

  task automatic half();
    repeat (4) @(negedge mclk);
  endtask

  // start or repeated start, ends with scl low
  task automatic start();
    sda_pull = 1'b0;
    half();
    scl_pull = 1'b0;
    half();
    sda_pull = 1'b1;
    half();
    scl_pull = 1'b1;
    qtr();
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    qtr();
    scl_pull = 1'b0;
    half();
    sda_pull = 1'b0;
    half();
  endtask

  // bits msb first, sda moves only while scl low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull = !b[i];
      qtr();
      scl_pull = 1'b0;
      half();
      scl_pull = 1'b1;
      qtr();
    end
    sda_pull = 1'b0;
    // slave acks several cycles after its filtered fall; stay low until then
    half();
    qtr();
    scl_pull = 1'b0;
    half();
    ack = (sda === 1'b0);
    scl_pull = 1'b1;
    // long low phase: slave may hold its ack past the fall
    half();
    half();
  endtask
endmodule

// ### i2c_addr_match_sva.sv
// assertion checker for the address matcher ports
module i2c_addr_match_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sda_in,
  input wire logic master_active,
  input wire logic flag_clear,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic addressed_as_slave_flag,
  input wire logic slave_transmit,
  input wire logic transfer_pulse,
  input wire logic bus_idle_high_timeout_flag,
  input wire logic data_low_timeout_flag,
  input wire logic clock_low_timeout_flag,
  input wire logic module_interrupt_flag,
  input wire logic master_extension_flag,
  input wire logic slave_extension_flag,
  input wire logic master_stop_request
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  release_lines_a: assert property (!scl_oe && !scl_out && !sda_out)
    else $error("clock or data driven high");
  ack_needs_match_a: assert property ($rose(sda_oe) |-> addressed_as_slave_flag || $past(transfer_pulse))
    else $error("ack without addressed flag");
  ack_holds_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
    else $error("ack too short");
  pulse_single_a: assert property (transfer_pulse |=> !transfer_pulse)
    else $error("transfer pulse too long");
  pulse_irq_a: assert property (transfer_pulse |=> module_interrupt_flag)
    else $error("pulse did not set interrupt");
  irq_sticky_a: assert property (module_interrupt_flag && !flag_clear |=> module_interrupt_flag)
    else $error("interrupt flag dropped");
  dlow_irq_a: assert property ($rose(data_low_timeout_flag) |-> ##[0:1] module_interrupt_flag)
    else $error("data low without interrupt");
  master_extension_flag_low_a: assert property ($rose(master_extension_flag) |-> ##[0:1] clock_low_timeout_flag)
    else $error("master stretch without low flag");
  slave_extension_flag_low_a: assert property ($rose(slave_extension_flag) |-> ##[0:1] clock_low_timeout_flag)
    else $error("slave stretch without low flag");
  idle_drop_a: assert property (!sda_in [*7] |-> !bus_idle_high_timeout_flag)
    else $error("idle flag with data low");
  stop_req_a: assert property (!master_active [*2] |-> !master_stop_request)
    else $error("stop request while not master");

  cover property (transfer_pulse);
  cover property ($rose(slave_transmit));
  cover property ($rose(data_low_timeout_flag));
  cover property ($rose(master_extension_flag));
endmodule

bind i2c_addr_match i2c_addr_match_sva i2c_addr_match_sva_i (
  .mclk, .nrst, .sda_in, .master_active, .flag_clear, .sda_out, .sda_oe, .scl_out, .scl_oe,
  .addressed_as_slave_flag, .slave_transmit, .transfer_pulse, .bus_idle_high_timeout_flag,
  .data_low_timeout_flag, .clock_low_timeout_flag, .module_interrupt_flag,
  .master_extension_flag, .slave_extension_flag, .master_stop_request
);

// ### tb_i2c_addr_match.sv
// testbench for address matching and smbus timeouts
module tb_i2c_addr_match;
  timeunit 1ns;
  timeprecision 1ns;
  import i2c_match_pkg::*;

  logic mclk, nrst, address_extension_enable, general_call_enable, alert_response_enable;
  logic second_address_enable, range_match_enable, master_active, master_stretching;
  logic slave_stretching, flag_clear, sda_out, sda_oe, scl_out, scl_oe;
  logic addressed_as_slave_flag, slave_transmit, transfer_pulse, bus_idle_high_timeout_flag;
  logic data_low_timeout_flag, clock_low_timeout_flag, module_interrupt_flag;
  logic master_extension_flag, slave_extension_flag, master_stop_request, scl_pull, sda_pull;
  logic [9:0] own_address;
  logic [6:0] second_address, range_address;
  logic [CNT_W-1:0] high_timeout_cycles, data_low_timeout_cycles;
  logic [CNT_W-1:0] master_ext_cycles, slave_ext_cycles;
  logic ack;
  int err_total = 0;
  int n_checks = 0;
  int np = 0;
  int np0;
  // bus lines with pull-ups: low while anyone pulls
  wire scl_in = !(scl_pull || scl_oe);
  wire sda_in = !(sda_pull || sda_oe);
  // {expect, gc, alert, second, range, byte}; own 2a, second 11, range 2d
  logic [12:0] tab [12] = '{13'h1054, 13'h0000, 13'h1800, 13'h1418, 13'h0018, 13'h1222,
                            13'h0022, 13'h115a, 13'h015c, 13'h1156, 13'h0056, 13'h0ff0};

  i2c_addr_match i2c_addr_match_i (
    .mclk, .nrst, .scl_in, .sda_in, .own_address, .address_extension_enable,
    .general_call_enable, .alert_response_enable, .second_address_enable, .second_address,
    .range_match_enable, .range_address, .master_active, .master_stretching,
    .slave_stretching, .high_timeout_cycles, .data_low_timeout_cycles, .master_ext_cycles,
    .slave_ext_cycles, .flag_clear, .sda_out, .sda_oe, .scl_out, .scl_oe,
    .addressed_as_slave_flag, .slave_transmit, .transfer_pulse, .bus_idle_high_timeout_flag,
    .data_low_timeout_flag, .clock_low_timeout_flag, .module_interrupt_flag,
    .master_extension_flag, .slave_extension_flag, .master_stop_request
  );

  i2c_master_model m (.mclk(mclk), .sda(sda_in), .scl_pull(scl_pull), .sda_pull(sda_pull));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (transfer_pulse === 1'b1)
      np <= np + 1;

  task automatic chk(input logic s, input logic e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: value differs", $time);
    end
  endtask

  task automatic clr();
    @(negedge mclk);
    flag_clear = 1'b1;
    @(negedge mclk);
    flag_clear = 1'b0;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end

  initial
  begin
    {nrst, address_extension_enable, general_call_enable, alert_response_enable} = 4'h0;
    {second_address_enable, range_match_enable, master_active} = 3'h0;
    {master_stretching, slave_stretching, flag_clear} = 3'h0;
    {high_timeout_cycles, data_low_timeout_cycles} = {24'h000000, 24'h000000};
    {master_ext_cycles, slave_ext_cycles} = {24'h000000, 24'h000000};
    own_address = 10'h02a;
    second_address = 7'h11;
    range_address = 7'h2d;
    wait_n(20);
    nrst = 1'b1;
    wait_n(8);
    // each optional address source on and off
    for (int i = 0; i < 12; i++)
    begin
      {general_call_enable, alert_response_enable, second_address_enable,
       range_match_enable} = tab[i][11:8];
      clr();
      m.start();
      m.wbyte(tab[i][7:0], ack);
      chk(ack, tab[i][12]);
      chk(addressed_as_slave_flag, tab[i][12]);
      m.stop();
    end
    $display("test seven bit done");
    {general_call_enable, alert_response_enable, second_address_enable,
     range_match_enable} = 4'h0;
    own_address = 10'h2a5;
    address_extension_enable = 1'b1;
    clr();
    np0 = np;
    m.start();
    // first byte 11110, high bits 10, write
    m.wbyte(8'hf4, ack);
    chk(ack, 1'b1);
    chk(np == np0 + 1, 1'b1);
    m.wbyte(8'ha5, ack);
    chk(ack, 1'b1);
    m.start();
    m.wbyte(8'hf5, ack);
    chk(ack, 1'b1);
    chk(slave_transmit, 1'b1);
    m.stop();
    wait_n(8);
    chk(slave_transmit, 1'b0);
    m.start();
    m.wbyte(8'hf2, ack);
    chk(ack, 1'b0);
    m.start();
    m.wbyte(8'hf4, ack);
    m.wbyte(8'ha4, ack);
    chk(ack, 1'b0);
    m.start();
    m.wbyte(8'hf5, ack);
    chk(ack, 1'b0);
    m.stop();
    $display("test ten bit done");
    address_extension_enable = 1'b0;
    high_timeout_cycles = 24'h0000c8;
    data_low_timeout_cycles = 24'h000064;
    master_ext_cycles = 24'h000032;
    slave_ext_cycles = 24'h000032;
    clr();
    wait_n(250);
    chk(bus_idle_high_timeout_flag, 1'b1);
    // idle seen, the bus is free to claim
    m.hold_sda(1'b1);
    wait_n(150);
    chk(bus_idle_high_timeout_flag, 1'b0);
    chk(data_low_timeout_flag, 1'b1);
    chk(module_interrupt_flag, 1'b1);
    m.hold_sda(1'b0);
    wait_n(8);
    clr();
    chk(data_low_timeout_flag, 1'b0);
    m.start();
    master_active = 1'b1;
    master_stretching = 1'b1;
    wait_n(80);
    chk(master_extension_flag, 1'b1);
    chk(clock_low_timeout_flag, 1'b1);
    chk(master_stop_request, 1'b1);
    master_stretching = 1'b0;
    // repeated start ends the byte, so the saturated master count restarts
    m.start();
    clr();
    slave_stretching = 1'b1;
    wait_n(80);
    chk(slave_extension_flag, 1'b1);
    chk(clock_low_timeout_flag, 1'b1);
    chk(master_extension_flag, 1'b0);
    slave_stretching = 1'b0;
    master_active = 1'b0;
    m.stop();
    wait_n(8);
    chk(master_stop_request, 1'b0);
    $display("test timeouts done");
    test_done();
  end
endmodule
